// ---- rtl/sli_pkg.sv ----
// constants for the serial link interrupt enable and status block
//
// Operation
// R1 - eight read/write event enables, reset to zero
// R2 - checksum event compares sent and computed checksum
// R3 - checksum event ignores programmed configuration checksum
// R4 - mismatch event when received and programmed parameters differ
// R5 - mismatch lane 0 only; enable bit 0
// R6 - mismatch compares every parameter including checksum
// R7 - status bits mirror enable positions, two registers
// R8 - request only when status and enable set
package sli_pkg;

	// ==========================================================
	// register map
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam logic [11:0] ADDR_EVENT_ENABLE = 12'h4b8;
	localparam logic [11:0] ADDR_MISMATCH_ENABLE = 12'h4b9;
	localparam logic [11:0] ADDR_EVENT_STATUS = 12'h4ba;
	localparam logic [11:0] ADDR_MISMATCH_STATUS = 12'h4bb;
	localparam logic [7:0] RESET_ENABLE = 8'h00;
	localparam logic [7:0] RESET_STATUS = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	// ==========================================================
	// bit positions, shared by enable and status registers
	localparam int BIT_BAD_DISPARITY = 7;
	localparam int BIT_NOT_IN_TABLE = 6;
	localparam int BIT_UNEXPECTED_CONTROL_CHAR = 5;
	localparam int BIT_INTERLANE_DESKEW = 4;
	localparam int BIT_INITIAL_LANE_SYNC = 3;
	localparam int BIT_GOOD_CHECKSUM = 2;
	localparam int BIT_FRAME_SYNC = 1;
	localparam int BIT_CODE_GROUP_SYNC = 0;
	localparam int BIT_CONFIG_MISMATCH = 0;

	// ==========================================================
	// lane alignment parameter block: octets 0..13, checksum last
	localparam int ILAS_OCTETS = 14;
	localparam int ILAS_CHECKSUM_OCTET = 13;
	localparam int ILAS_W = ILAS_OCTETS * 8;

endpackage

// ---- rtl/sli_ilas_check.sv ----
// lane 0 alignment data checker: checksum and configuration mismatch events
`timescale 1ns/10ps
module sli_ilas_check #(
	parameter int OCTETS = sli_pkg::ILAS_OCTETS,
	parameter int CKS_OCTET = sli_pkg::ILAS_CHECKSUM_OCTET
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ilas_done,
	input wire logic [OCTETS*8-1:0] ilas_rx_data,
	input wire logic [OCTETS*8-1:0] cfg_params,
	output logic good_checksum,
	output logic config_mismatch
);

	typedef struct packed {
		logic good_checksum;
		logic config_mismatch;
	} sli_chk_state_t;

	sli_chk_state_t state_reg;
	sli_chk_state_t state_next;

	// ==========================================================
	// checksum from received octets only; the programmed copy never enters here
	logic [7:0] computed_cks;
	always_comb begin
		computed_cks = 8'h00;
		for (int i = 0; i < OCTETS; i++) begin
			if (i != CKS_OCTET) begin
				computed_cks = computed_cks + ilas_rx_data[i*8 +: 8]; // [R2] [R3]
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.good_checksum = ilas_done
			&& (computed_cks == ilas_rx_data[CKS_OCTET*8 +: 8]); // [R2]
		// whole block compared, checksum octet included
		state_next.config_mismatch = ilas_done && (ilas_rx_data != cfg_params); // [R4] [R6]
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign good_checksum = state_reg.good_checksum;
	assign config_mismatch = state_reg.config_mismatch;

endmodule

// ---- rtl/sli_irq_enable.sv ----
// interrupt enable, status and request logic of the serial link receiver
`timescale 1ns/10ps
module sli_irq_enable (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic evt_bad_disparity,
	input wire logic evt_not_in_table,
	input wire logic evt_unexpected_control_char,
	input wire logic evt_interlane_deskew,
	input wire logic evt_initial_lane_sync,
	input wire logic evt_frame_sync,
	input wire logic evt_code_group_sync,
	input wire logic ilas_lane0_done,
	input wire logic [sli_pkg::ILAS_W-1:0] ilas_lane0_data,
	input wire logic [sli_pkg::ILAS_W-1:0] cfg_ilas_params,
	output logic irq_request
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] event_enable;
		logic config_mismatch_enable;
		logic [7:0] event_status;
		logic config_mismatch_status;
		logic [7:0] rdata;
		logic rvalid;
		logic irq;
	} sli_state_t;

	sli_state_t state_reg;
	sli_state_t state_next;

	// ==========================================================
	// lane 0 alignment checks
	// the checker registers its results, so alignment events reach the
	// status registers one edge later than the pin events do
	logic good_checksum;
	logic config_mismatch;

	sli_ilas_check #(
		.OCTETS(sli_pkg::ILAS_OCTETS),
		.CKS_OCTET(sli_pkg::ILAS_CHECKSUM_OCTET)
	) u_ilas_check (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ilas_done(ilas_lane0_done), // [R5]
		.ilas_rx_data(ilas_lane0_data),
		.cfg_params(cfg_ilas_params),
		.good_checksum(good_checksum),
		.config_mismatch(config_mismatch)
	);

	// ==========================================================
	// event vector in register bit order
	// the good-checksum bit comes from the lane 0 checker, not from a pin
	logic [7:0] event_in;
	always_comb begin
		event_in = 8'h00;
		event_in[sli_pkg::BIT_BAD_DISPARITY] = evt_bad_disparity;
		event_in[sli_pkg::BIT_NOT_IN_TABLE] = evt_not_in_table;
		event_in[sli_pkg::BIT_UNEXPECTED_CONTROL_CHAR] = evt_unexpected_control_char;
		event_in[sli_pkg::BIT_INTERLANE_DESKEW] = evt_interlane_deskew;
		event_in[sli_pkg::BIT_INITIAL_LANE_SYNC] = evt_initial_lane_sync;
		event_in[sli_pkg::BIT_GOOD_CHECKSUM] = good_checksum;
		event_in[sli_pkg::BIT_FRAME_SYNC] = evt_frame_sync;
		event_in[sli_pkg::BIT_CODE_GROUP_SYNC] = evt_code_group_sync;
	end

	// ==========================================================
	// register decode
	// one address match per register; an unmapped address matches none, so a
	// stray write is dropped and a stray read answers zero
	logic sel_event_enable;
	logic sel_mismatch_enable;
	logic sel_event_status;
	logic sel_mismatch_status;

	assign sel_event_enable = (reg_addr == sli_pkg::ADDR_EVENT_ENABLE);
	assign sel_mismatch_enable = (reg_addr == sli_pkg::ADDR_MISMATCH_ENABLE);
	assign sel_event_status = (reg_addr == sli_pkg::ADDR_EVENT_STATUS);
	assign sel_mismatch_status = (reg_addr == sli_pkg::ADDR_MISMATCH_STATUS);

	logic wr_event_enable;
	logic wr_mismatch_enable;
	logic wr_event_status;
	logic wr_mismatch_status;

	assign wr_event_enable = reg_wr && sel_event_enable;
	assign wr_mismatch_enable = reg_wr && sel_mismatch_enable;
	assign wr_event_status = reg_wr && sel_event_status;
	assign wr_mismatch_status = reg_wr && sel_mismatch_status;

	// only bit 0 of the second enable register is stored; bits 7:1 are dropped
	logic mismatch_enable_wdata;
	assign mismatch_enable_wdata = reg_wdata[sli_pkg::BIT_CONFIG_MISMATCH]; // [R5]

	// ==========================================================
	// write-one-to-clear masks for the status registers
	logic [7:0] event_clear;
	logic mismatch_clear;

	assign event_clear = {8{wr_event_status}} & reg_wdata; // [R7]
	assign mismatch_clear = wr_mismatch_status & reg_wdata[sli_pkg::BIT_CONFIG_MISMATCH]; // [R7]

	// ==========================================================
	// sticky status, one per bit; writing one clears, but an event in the
	// same cycle wins so that nothing arriving during the clear is lost
	logic [7:0] event_status_next;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_status
			assign event_status_next[gi] = event_in[gi]
				| (state_reg.event_status[gi] & ~event_clear[gi]); // [R7]
		end
	endgenerate

	logic mismatch_status_next;
	assign mismatch_status_next = config_mismatch
		| (state_reg.config_mismatch_status & ~mismatch_clear); // [R4] [R7]

	// ==========================================================
	// pending sources: a disabled source still latches its status bit but
	// never reaches the request, so software can poll without interrupts
	logic [7:0] event_pending;
	logic mismatch_pending;
	logic any_pending;

	generate
		for (gi = 0; gi < 8; gi++) begin : g_pending
			assign event_pending[gi] = state_reg.event_status[gi]
				& state_reg.event_enable[gi]; // [R8]
		end
	endgenerate

	assign mismatch_pending = state_reg.config_mismatch_status
		& state_reg.config_mismatch_enable; // [R5] [R8]
	assign any_pending = (|event_pending) | mismatch_pending; // [R8]

	// ==========================================================
	// read mux; bits 7:1 of the second enable and status registers are
	// not stored, so their views tie them to zero
	logic [7:0] mismatch_enable_view;
	logic [7:0] mismatch_status_view;
	logic [7:0] rdata_mux;

	assign mismatch_enable_view = {7'h00, state_reg.config_mismatch_enable}; // [R5]
	assign mismatch_status_view = {7'h00, state_reg.config_mismatch_status}; // [R7]

	always_comb begin
		rdata_mux = sli_pkg::RDATA_UNMAPPED;
		unique case (reg_addr)
			sli_pkg::ADDR_EVENT_ENABLE: begin
				rdata_mux = state_reg.event_enable; // [R1]
			end
			sli_pkg::ADDR_MISMATCH_ENABLE: begin
				rdata_mux = mismatch_enable_view; // [R5]
			end
			sli_pkg::ADDR_EVENT_STATUS: begin
				rdata_mux = state_reg.event_status; // [R7]
			end
			sli_pkg::ADDR_MISMATCH_STATUS: begin
				rdata_mux = mismatch_status_view; // [R7]
			end
			default: begin
				// unmapped addresses answer with zero rather than stalling the bus
				rdata_mux = sli_pkg::RDATA_UNMAPPED;
			end
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;

		if (wr_event_enable) begin
			state_next.event_enable = reg_wdata; // [R1]
		end
		// upper seven bits of the second enable register do not exist
		if (wr_mismatch_enable) begin
			state_next.config_mismatch_enable = mismatch_enable_wdata; // [R5]
		end

		state_next.event_status = event_status_next;
		state_next.config_mismatch_status = mismatch_status_next;

		// read data registered one cycle after the strobe; a read in the same
		// cycle as a write to that register returns the old value
		state_next.rvalid = reg_rd;
		state_next.rdata = reg_rd ? rdata_mux : sli_pkg::RDATA_UNMAPPED;

		// request follows the registered status, so it lags an event by two edges
		state_next.irq = any_pending; // [R8]
	end

	// ==========================================================
	// state register
	// enables and status clear together, so no request survives a reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg.event_enable <= sli_pkg::RESET_ENABLE; // [R1]
			state_reg.config_mismatch_enable <= 1'b0;
			state_reg.event_status <= sli_pkg::RESET_STATUS;
			state_reg.config_mismatch_status <= 1'b0;
			state_reg.rdata <= 8'h00;
			state_reg.rvalid <= 1'b0;
			state_reg.irq <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign reg_rvalid = state_reg.rvalid;
	assign irq_request = state_reg.irq;

endmodule

// ---- verification/sli_irq_enable_asserts.sv ----
// port checker for the interrupt enable block
`timescale 1ns/10ps
module sli_irq_enable_asserts (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic evt_frame_sync,
	input wire logic ilas_lane0_done,
	input wire logic irq_request
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_rvalid_lat: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
	a_rvalid_only: assert property (!reg_rd |=> !reg_rvalid) else $error("stray answer");
	a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
		else $error("rdata not idle");
	a_enb_rsvd: assert property (reg_rd && reg_addr == 12'h4b9 |=> reg_rdata[7:1] == 7'h00)
		else $error("reserved enable bits");
	a_stsb_rsvd: assert property (reg_rd && reg_addr == 12'h4bb |=> reg_rdata[7:1] == 7'h00)
		else $error("reserved status bits");
	a_enable_echo: assert property ((reg_wr && reg_addr == 12'h4b8) ##1 !reg_wr
		##1 (reg_rd && !reg_wr && reg_addr == 12'h4b8) |=> reg_rdata == $past(reg_wdata, 3))
		else $error("enable readback");
	a_irq_frame: assert property ((reg_wr && reg_addr == 12'h4b8 && reg_wdata[1]) ##1 !reg_wr
		##1 (!reg_wr && evt_frame_sync) ##1 !reg_wr |=> irq_request) else $error("irq missing");
	a_rst_quiet: assert property ($past(sys_rst) |-> !irq_request && !reg_rvalid)
		else $error("outputs after reset");
	c_irq: cover property ($rose(irq_request));
	c_read: cover property (reg_rd ##1 reg_rvalid);
	c_ilas: cover property (ilas_lane0_done);
endmodule
bind sli_irq_enable sli_irq_enable_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .evt_frame_sync(evt_frame_sync),
	.ilas_lane0_done(ilas_lane0_done), .irq_request(irq_request));

// ---- verification/sli_tx_model.sv ----
// transmitter model: one lane 0 alignment block per request
`timescale 1ns/10ps
module sli_tx_model (
	input wire logic mclk,
	input wire logic send,
	input wire logic bad_cks,
	input wire logic [103:0] base,
	output logic done,
	output logic [111:0] data
);
	logic [7:0] sum;
	always_comb begin
		sum = 8'h00;
		for (int i = 0; i < 13; i++) sum += base[8*i +: 8];
	end
	initial done = 1'b0;
	initial data = '0;
	always @(posedge mclk) begin
		done <= send;
		// between blocks the lane toggles, so stale data cannot pass for valid
		if (send) data <= {sum ^ {8{bad_cks}}, base};
		else data <= ~data;
	end
endmodule

// ---- verification/sli_irq_enable_tb.sv ----
// self-checking bench for the interrupt enable block
`timescale 1ns/10ps
module sli_irq_enable_tb;
	logic mclk, sys_rst, reg_wr, reg_rd, done, send, bad_cks, irq, rv;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, ev;
	logic [111:0] data, cfg;
	int error_cnt = 0;
	int tests_run = 0;
	localparam logic [111:0] FRAME = {8'h0d, {13{8'h01}}};
	sli_irq_enable u_sli_irq_enable (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(rv), .evt_bad_disparity(ev[7]), .evt_not_in_table(ev[6]),
		.evt_unexpected_control_char(ev[5]), .evt_interlane_deskew(ev[4]),
		.evt_initial_lane_sync(ev[3]), .evt_frame_sync(ev[1]), .evt_code_group_sync(ev[0]),
		.ilas_lane0_done(done), .ilas_lane0_data(data), .cfg_ilas_params(cfg), .irq_request(irq));
	sli_tx_model u_sli_tx_model (.mclk(mclk), .send(send), .bad_cks(bad_cks),
		.base({13{8'h01}}), .done(done), .data(data));
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read answer has a fixed one-cycle latency
	task automatic rd(logic [11:0] a, logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", 8'h01, {7'h00, rv});
		chk("rdata", e, reg_rdata);
	endtask
	task automatic pulse(logic [7:0] v);
		@(posedge mclk);
		ev <= v;
		@(posedge mclk);
		ev <= 8'h00;
	endtask
	task automatic tx(logic b);
		@(posedge mclk);
		send <= 1'b1;
		bad_cks <= b;
		@(posedge mclk);
		send <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
	task automatic irq_is(logic e);
		repeat (2) @(posedge mclk);
		#1;
		chk("irq", {7'h00, e}, {7'h00, irq});
	endtask
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#2ms;
		error_cnt++;
		results();
	end
	// ====
	// main sequence
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, send, bad_cks, reg_addr, reg_wdata, ev} = '0;
		cfg = FRAME;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 5; a++) rd(12'h4b8 + 12'(a), 8'h00);
		wr(12'h4b8, 8'hff);
		rd(12'h4b8, 8'hff);
		wr(12'h4b9, 8'hff);
		rd(12'h4b9, 8'h01);
		wr(12'h4bc, 8'h5a);
		rd(12'h4bc, 8'h00);
		wr(12'h4b9, 8'h00);
		wr(12'h4b8, 8'h00);
		pulse(8'hfb);
		irq_is(1'b0);
		rd(12'h4ba, 8'hfb);
		wr(12'h4ba, 8'hff);
		rd(12'h4ba, 8'h00);
		$display("registers done");
		for (int k = 0; k < 8; k++) if (k != 2) begin
			wr(12'h4b8, 8'h01 << k);
			pulse(8'h01 << k);
			irq_is(1'b1);
			rd(12'h4ba, 8'h01 << k);
			wr(12'h4ba, 8'h01 << k);
			irq_is(1'b0);
			wr(12'h4b8, 8'h00);
		end
		// event and clear sampled at one edge: the event must survive
		@(posedge mclk);
		ev <= 8'h01;
		reg_wr <= 1'b1;
		reg_addr <= 12'h4ba;
		reg_wdata <= 8'h01;
		@(posedge mclk);
		ev <= 8'h00;
		reg_wr <= 1'b0;
		rd(12'h4ba, 8'h01);
		wr(12'h4ba, 8'h01);
		$display("events done");
		wr(12'h4b9, 8'h01);
		tx(1'b0);
		rd(12'h4ba, 8'h04);
		rd(12'h4bb, 8'h00);
		irq_is(1'b0);
		wr(12'h4ba, 8'h04);
		cfg <= FRAME ^ {8'hff, 104'h0};
		tx(1'b0);
		rd(12'h4ba, 8'h04);
		rd(12'h4bb, 8'h01);
		irq_is(1'b1);
		wr(12'h4ba, 8'h04);
		wr(12'h4bb, 8'h01);
		cfg <= FRAME;
		tx(1'b1);
		rd(12'h4ba, 8'h00);
		rd(12'h4bb, 8'h01);
		irq_is(1'b1);
		wr(12'h4bb, 8'h01);
		cfg <= FRAME ^ 112'h1;
		tx(1'b0);
		rd(12'h4ba, 8'h04);
		rd(12'h4bb, 8'h01);
		wr(12'h4b9, 8'h00);
		irq_is(1'b0);
		$display("alignment done");
		results();
	end
endmodule
